// file: write_queue_pkg.sv
package write_queue_pkg;

  localparam int unsigned OFS_W = 12;

  // Register byte offsets
  localparam logic [OFS_W-1:0] OFS_PTR     = 12'h000;
  localparam logic [OFS_W-1:0] OFS_CFG     = 12'h004;
  localparam logic [OFS_W-1:0] OFS_PAUSEEN = 12'h008;
  localparam logic [OFS_W-1:0] OFS_FLAGS   = 12'h00C;
  localparam logic [OFS_W-1:0] OFS_SETCLR  = 12'h010;
  localparam logic [OFS_W-1:0] OFS_IRQMASK = 12'h014;
  localparam logic [OFS_W-1:0] OFS_CURIDX  = 12'h018;
  localparam logic [OFS_W-1:0] OFS_ENDIDX  = 12'h01C;
  localparam logic [OFS_W-1:0] OFS_CMD     = 12'h020;
  localparam logic [OFS_W-1:0] OFS_STATUS  = 12'h024;

  // Field positions
  localparam int unsigned CFG_EN_BIT   = 0;
  localparam int unsigned SC_SET_LSB   = 0;
  localparam int unsigned SC_CLR_LSB   = 8;
  localparam int unsigned SC_TGL_LSB   = 16;
  localparam int unsigned NUM_FLAGS    = 8;
  localparam int unsigned NUM_EXT      = 7;
  localparam int unsigned NUM_PAUSE    = 16;
  localparam int unsigned IDX_PAUSE    = 15;
  localparam int unsigned ST_PAUSE_LSB = 16;

  localparam logic [31:0] WORD_STEP  = 32'h0000_0004;
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
  localparam logic [15:0] RST_HALF   = 16'h0000;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLERR = 2'h2;

  typedef enum logic [2:0] {
    Q_IDLE      = 3'b000,
    Q_FETCH_OFS = 3'b001,
    Q_FETCH_VAL = 3'b010,
    Q_APPLY     = 3'b011,
    Q_WAIT_XACT = 3'b100,
    Q_NEXT      = 3'b101,
    Q_PAUSED    = 3'b110
  } queue_state_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
  } mem_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } mem_rsp_t;

  typedef struct packed {
    logic             valid;
    logic [OFS_W-1:0] offset;
    logic [31:0]      data;
  } unit_wr_t;

endpackage : write_queue_pkg

// file: register_write_queue.sv
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
module register_write_queue
  import write_queue_pkg::*;
(
  input  wire logic               clock_i,
  input  wire logic               rst_n_i,
  input  wire axi_req_t           axi_i,
  output axi_rsp_t                axi_o,
  output mem_req_t                mem_o,
  input  wire mem_rsp_t           mem_i,
  output unit_wr_t                unit_wr_o,
  output logic                    cmd_start_o,
  output logic [31:0]             cmd_word_o,
  input  wire logic               xact_done_i,
  input  wire logic [NUM_EXT-1:0] ext_pause_i,
  output logic                    queue_paused_event_o
);

  typedef struct packed {
    queue_state_t     fsm;
    logic [31:0]      ptr;
    logic             en;
    logic [15:0]      pause_en;
    logic [7:0]       flags;
    logic [15:0]      irq_mask;
    logic [7:0]       cur_idx;
    logic [7:0]       end_idx;
    logic             grace;
    logic [OFS_W-1:0] ofs;
    logic [31:0]      val;
    mem_req_t         mem;
    unit_wr_t         unit_wr;
    logic             cmd_start;
    logic [31:0]      cmd_word;
    logic             irq;
    logic             aw_got;
    logic [31:0]      awaddr;
    logic             w_got;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    axi_rsp_t         axi;
  } state_t;

  state_t st;
  state_t next_st;

  logic [NUM_PAUSE-1:0] pause_src;
  logic                 pause_hit;

  function automatic logic is_mapped(input logic [OFS_W-1:0] ofs);
    is_mapped = (ofs == OFS_PTR) || (ofs == OFS_CFG) || (ofs == OFS_PAUSEEN)
             || (ofs == OFS_FLAGS) || (ofs == OFS_SETCLR) || (ofs == OFS_IRQMASK)
             || (ofs == OFS_CURIDX) || (ofs == OFS_ENDIDX) || (ofs == OFS_CMD)
             || (ofs == OFS_STATUS);
  endfunction : is_mapped

  function automatic logic [31:0] read_reg(input state_t s, input logic [OFS_W-1:0] ofs,
                                           input logic [NUM_PAUSE-1:0] src);
    read_reg = RST_WORD;
    unique case (ofs)
      OFS_PTR:     read_reg = s.ptr;
      OFS_CFG:     read_reg[CFG_EN_BIT] = s.en;
      OFS_PAUSEEN: read_reg[15:0] = s.pause_en;
      OFS_FLAGS:   read_reg[7:0] = s.flags;
      OFS_IRQMASK: read_reg[15:0] = s.irq_mask;
      OFS_CURIDX:  read_reg[7:0] = s.cur_idx;
      OFS_ENDIDX:  read_reg[7:0] = s.end_idx;
      OFS_CMD:     read_reg = s.cmd_word;
      OFS_STATUS:  read_reg = {src, RST_BYTE, 5'h00, s.fsm};
      default:     read_reg = RST_WORD;
    endcase
  endfunction : read_reg

  // Shared by the bus and the queue, so a queued write acts as a processor write
  function automatic state_t write_reg(input state_t s, input logic [OFS_W-1:0] ofs,
                                       input logic [31:0] d);
    state_t r;
    r = s;
    unique case (ofs)
      OFS_PTR:     r.ptr = {d[31:2], 2'b00};
      OFS_CFG:     r.en = d[CFG_EN_BIT];
      OFS_PAUSEEN: r.pause_en = d[15:0];
      OFS_FLAGS:   r.flags = d[7:0];
      OFS_SETCLR:  r.flags = ((s.flags | d[SC_SET_LSB +: NUM_FLAGS])
                             & ~d[SC_CLR_LSB +: NUM_FLAGS])
                             ^ d[SC_TGL_LSB +: NUM_FLAGS];
      OFS_IRQMASK: r.irq_mask = d[15:0];
      OFS_CURIDX:  r.cur_idx = d[7:0];
      OFS_ENDIDX:  r.end_idx = d[7:0];
      OFS_CMD: begin
        r.cmd_word  = d;
        r.cmd_start = 1'b1;
      end
      default:     r = s;
    endcase
    return r;
  endfunction : write_reg

  // Sources 14:8 are the flag XOR its external line
  genvar g;
  generate
    for (g = 0; g < NUM_FLAGS; g++) begin : g_flag_src
      assign pause_src[g] = st.flags[g];
    end
    for (g = 0; g < NUM_EXT; g++) begin : g_ext_src
      assign pause_src[NUM_FLAGS+g] = st.flags[g] ^ ext_pause_i[g];
    end
  endgenerate
  assign pause_src[IDX_PAUSE] = (st.cur_idx == st.end_idx);
  assign pause_hit = |(pause_src & st.pause_en);

  always_comb begin
    logic [31:0]      wmask;
    logic [31:0]      wword;
    logic [OFS_W-1:0] aofs;
    logic [OFS_W-1:0] rofs;
    wmask = RST_WORD;
    wword = RST_WORD;
    aofs  = st.awaddr[OFS_W-1:0];
    rofs  = axi_i.araddr[OFS_W-1:0];
    next_st = st;
    next_st.unit_wr.valid = 1'b0;
    next_st.cmd_start     = 1'b0;
    next_st.irq           = |(pause_src & st.pause_en & st.irq_mask);

    unique case (st.fsm)
      Q_IDLE: begin
        if (st.en) begin
          // First entry is fetched without looking at the pause sources
          next_st.mem.req  = 1'b1;
          next_st.mem.addr = st.ptr;
          next_st.grace    = 1'b0;
          next_st.fsm      = Q_FETCH_OFS;
        end
      end
      Q_FETCH_OFS: begin
        if (mem_i.ack) begin
          next_st.ofs      = {mem_i.rdata[OFS_W-1:2], 2'b00};
          next_st.ptr      = st.ptr + WORD_STEP;
          next_st.mem.addr = st.ptr + WORD_STEP;
          next_st.fsm      = Q_FETCH_VAL;
        end
      end
      Q_FETCH_VAL: begin
        if (mem_i.ack) begin
          next_st.val     = mem_i.rdata;
          next_st.ptr     = st.ptr + WORD_STEP;
          next_st.mem.req = 1'b0;
          next_st.fsm     = Q_APPLY;
        end
      end
      Q_APPLY: begin
        next_st = write_reg(next_st, st.ofs, st.val);
        if (!is_mapped(st.ofs)) begin
          next_st.unit_wr.valid  = 1'b1;
          next_st.unit_wr.offset = st.ofs;
          next_st.unit_wr.data   = st.val;
        end
        // The pause check is skipped for the next entry after a queued OFS_SETCLR write
        next_st.grace = (st.ofs == OFS_SETCLR);
        next_st.fsm   = (st.ofs == OFS_CMD) ? Q_WAIT_XACT : Q_NEXT;
      end
      Q_WAIT_XACT: begin
        if (xact_done_i) begin
          next_st.fsm = Q_NEXT;
        end
      end
      Q_NEXT: begin
        next_st.grace = 1'b0;
        if (!st.en) begin
          next_st.fsm = Q_IDLE;
        end else if (pause_hit && !st.grace) begin
          next_st.fsm = Q_PAUSED;
        end else begin
          next_st.mem.req  = 1'b1;
          next_st.mem.addr = st.ptr;
          next_st.fsm      = Q_FETCH_OFS;
        end
      end
      Q_PAUSED: begin
        if (!st.en) begin
          next_st.fsm = Q_IDLE;
        end else if (!pause_hit) begin
          next_st.mem.req  = 1'b1;
          next_st.mem.addr = st.ptr;
          next_st.fsm      = Q_FETCH_OFS;
        end
      end
      default: begin
        next_st.fsm     = Q_IDLE;
        next_st.mem.req = 1'b0;
      end
    endcase

    // Bus write channels; held off during a queued apply so the two never collide
    if (axi_i.awvalid && st.axi.awready) begin
      next_st.aw_got      = 1'b1;
      next_st.awaddr      = axi_i.awaddr;
      next_st.axi.awready = 1'b0;
    end
    if (axi_i.wvalid && st.axi.wready) begin
      next_st.w_got      = 1'b1;
      next_st.wdata      = axi_i.wdata;
      next_st.wstrb      = axi_i.wstrb;
      next_st.axi.wready = 1'b0;
    end
    if (st.aw_got && st.w_got && !st.axi.bvalid && st.fsm != Q_APPLY) begin
      for (int i = 0; i < 4; i++) begin
        wmask[i*8 +: 8] = {8{st.wstrb[i]}};
      end
      wword = (read_reg(st, aofs, pause_src) & ~wmask) | (st.wdata & wmask);
      if (is_mapped(aofs)) begin
        next_st = write_reg(next_st, aofs, wword);
        next_st.axi.bresp = RESP_OKAY;
      end else begin
        next_st.axi.bresp = RESP_SLERR;
      end
      next_st.aw_got     = 1'b0;
      next_st.w_got      = 1'b0;
      next_st.axi.bvalid = 1'b1;
    end
    if (st.axi.bvalid && axi_i.bready) begin
      next_st.axi.bvalid  = 1'b0;
      next_st.axi.awready = 1'b1;
      next_st.axi.wready  = 1'b1;
    end

    // Read channel
    if (axi_i.arvalid && st.axi.arready) begin
      next_st.axi.arready = 1'b0;
      next_st.axi.rvalid  = 1'b1;
      next_st.axi.rdata   = read_reg(st, rofs, pause_src);
      next_st.axi.rresp   = is_mapped(rofs) ? RESP_OKAY : RESP_SLERR;
    end
    if (st.axi.rvalid && axi_i.rready) begin
      next_st.axi.rvalid  = 1'b0;
      next_st.axi.arready = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st             <= '0;
      st.fsm         <= Q_IDLE;
      st.axi.awready <= 1'b1;
      st.axi.wready  <= 1'b1;
      st.axi.arready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign axi_o                = st.axi;
  assign mem_o                = st.mem;
  assign unit_wr_o            = st.unit_wr;
  assign cmd_start_o          = st.cmd_start;
  assign cmd_word_o           = st.cmd_word;
  assign queue_paused_event_o = st.irq;

endmodule : register_write_queue

// file: write_queue_chk.sv
module write_queue_chk
  import write_queue_pkg::*;
(
  input  wire logic     clock_i,
  input  wire logic     rst_n_i,
  input  wire mem_req_t mem_o,
  input  wire mem_rsp_t mem_i,
  input  wire unit_wr_t unit_wr_o,
  input  wire logic     cmd_start_o,
  input  wire logic     xact_done_i
);
  logic half;
  logic wait_x;
  // Tracks which word of an entry the next acknowledge closes
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      half   <= 1'b0;
      wait_x <= 1'b0;
    end else begin
      if (mem_o.req && mem_i.ack) half <= !half;
      if (cmd_start_o) wait_x <= 1'b1;
      else if (xact_done_i) wait_x <= 1'b0;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_first_word;
    mem_o.req && mem_i.ack && !half;
  endsequence
  sequence s_last_word;
    mem_o.req && mem_i.ack && half;
  endsequence
  a_addr_aligned: assert property (mem_o.req |-> mem_o.addr[1:0] == 2'h0)
    else $error("fetch address not aligned");
  a_value_next: assert property (s_first_word |=> mem_o.req
    && mem_o.addr == $past(mem_o.addr) + WORD_STEP)
    else $error("value word not fetched from next address");
  a_addr_hold: assert property (mem_o.req && !mem_i.ack |=> mem_o.req && $stable(mem_o.addr))
    else $error("fetch request dropped or moved before ack");
  a_no_prefetch: assert property (s_last_word |=> !mem_o.req [*2])
    else $error("fetch issued before entry applied");
  a_cmd_stall: assert property (wait_x |-> !mem_o.req)
    else $error("fetch during running transaction");
  a_apply_alone: assert property (unit_wr_o.valid |-> !mem_o.req && !cmd_start_o)
    else $error("apply overlaps fetch or command");
  a_wr_pulse: assert property (unit_wr_o.valid |=> !unit_wr_o.valid)
    else $error("unit write longer than one cycle");
  a_cmd_pulse: assert property (cmd_start_o |=> !cmd_start_o && !mem_o.req)
    else $error("command start not a single pulse");
endmodule : write_queue_chk

bind register_write_queue write_queue_chk write_queue_chk_i (.clock_i(clock_i),
  .rst_n_i(rst_n_i), .mem_o(mem_o), .mem_i(mem_i), .unit_wr_o(unit_wr_o),
  .cmd_start_o(cmd_start_o), .xact_done_i(xact_done_i));

// file: fetch_memory_model.sv
module fetch_memory_model
  import write_queue_pkg::*;
(
  input  wire logic     clock_i,
  input  wire logic     rst_n_i,
  input  wire logic     slow_i,
  input  wire mem_req_t req_i,
  output mem_rsp_t      rsp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] store [64];
  logic [1:0]  wait_cnt;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_o    <= '0;
      wait_cnt <= 2'h0;
    end else begin
      rsp_o.ack   <= 1'b0;
      // Data outside an ack keeps changing, so stale words cannot pass
      rsp_o.rdata <= ~rsp_o.rdata;
      if (req_i.req && !rsp_o.ack) begin
        if (!slow_i || wait_cnt == 2'h3) begin
          rsp_o.ack   <= 1'b1;
          rsp_o.rdata <= store[req_i.addr[7:2]];
          wait_cnt    <= 2'h0;
        end else begin
          wait_cnt <= wait_cnt + 2'h1;
        end
      end
    end
  end
endmodule : fetch_memory_model

// file: tb_register_write_queue.sv
module tb_register_write_queue
  import write_queue_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, rst_n_i, xact_done_i, slow, cmd_start_o, queue_paused_event_o;
  logic [NUM_EXT-1:0] ext_pause_i;
  logic [31:0]        cmd_word_o, d;
  logic [1:0]         r;
  axi_req_t           req;
  axi_rsp_t           rsp;
  mem_req_t           mreq;
  mem_rsp_t           mrsp;
  unit_wr_t           uw;
  int                 n_mismatch, samples_checked, dcnt;
  logic [31:0]        units [$];
  logic [31:0]        ofsq [$];
  localparam logic [31:0] BASE = 32'h0000_0040;

  register_write_queue register_write_queue_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .axi_i(req), .axi_o(rsp), .mem_o(mreq), .mem_i(mrsp), .unit_wr_o(uw),
    .cmd_start_o(cmd_start_o), .cmd_word_o(cmd_word_o), .xact_done_i(xact_done_i),
    .ext_pause_i(ext_pause_i), .queue_paused_event_o(queue_paused_event_o));
  fetch_memory_model fetch_memory_model_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .slow_i(slow), .req_i(mreq), .rsp_o(mrsp));

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // Each transaction ends six cycles after its start
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      dcnt        <= 0;
      xact_done_i <= 1'b0;
    end else begin
      if (uw.valid === 1'b1) begin
        units.push_back(uw.data);
        ofsq.push_back({20'h0_0000, uw.offset});
      end
      xact_done_i <= (dcnt == 1);
      if (cmd_start_o === 1'b1) dcnt <= 5;
      else if (dcnt > 0) dcnt <= dcnt - 1;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    $display("Mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic axw(input logic [11:0] a, input logic [31:0] v);
    int n;
    @(posedge clock_i);
    req.awaddr <= {20'h0_0000, a};
    req.wdata <= v;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clock_i);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    r = rsp.bresp;
    req.bready <= 1'b0;
    if (n == 200) begin
      n_mismatch++;
      close_out();
    end
  endtask : axw

  task automatic axr(input logic [11:0] a);
    int n;
    @(posedge clock_i);
    req.araddr <= {20'h0_0000, a};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clock_i);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
    if (n == 200) begin
      n_mismatch++;
      close_out();
    end
  endtask : axr

  task automatic wait_paused();
    int n;
    for (n = 0; n < 60; n++) begin
      axr(OFS_STATUS);
      if (d[2:0] === 3'h6) break;
    end
    if (n == 60) begin
      n_mismatch++;
      close_out();
    end
  endtask : wait_paused

  task automatic ld(input int k, input logic [31:0] o, input logic [31:0] v);
    fetch_memory_model_i.store[16+2*k] = o;
    fetch_memory_model_i.store[17+2*k] = v;
  endtask : ld

  task automatic t_regs();
    axr(OFS_PTR);
    chk("ptr reset", d, RST_WORD);
    axr(12'hFFC);
    chk("unmapped rresp", {30'h0, r}, {30'h0, RESP_SLERR});
    axw(12'hFFC, 32'h1234_5678);
    chk("unmapped bresp", {30'h0, r}, {30'h0, RESP_SLERR});
    axw(OFS_FLAGS, 32'h0000_000F);
    axw(OFS_SETCLR, 32'h0080_0130);
    axr(OFS_FLAGS);
    chk("flags set clear toggle", d, 32'h0000_00BE);
  endtask : t_regs

  task automatic t_queue();
    axw(OFS_FLAGS, 32'h0000_0001);
    axw(OFS_PAUSEEN, 32'h0000_0001);
    axw(OFS_IRQMASK, 32'h0000_8000);
    axw(OFS_PTR, BASE);
    axw(OFS_CFG, 32'h0000_0001);
    wait_paused();
    chk("first entry only", 32'(units.size()), 32'h1);
    chk("unit write a", units[0], 32'hA5A5_0001);
    chk("unit offset a", ofsq[0], 32'h0000_0100);
    axr(OFS_PTR);
    chk("ptr after start", d, BASE + 32'h0000_0008);
    chk("event masked", {31'h0, queue_paused_event_o}, 32'h0);
    slow <= 1'b0;
    axw(OFS_FLAGS, 32'h0000_0000);
    wait_paused();
    chk("extra entry runs", 32'(units.size()), 32'h3);
    chk("unit write d", units[2], 32'hA5A5_000D);
    chk("unit offset d", ofsq[2], 32'h0000_0108);
    chk("command word", cmd_word_o, 32'h0000_0C3D);
    axr(OFS_PTR);
    chk("ptr while paused", d, BASE + 32'h0000_0028);
    axw(OFS_SETCLR, 32'h0000_0100);
    wait_paused();
    chk("redirect skips", 32'(units.size()), 32'h3);
    axr(OFS_PTR);
    chk("ptr after redirect", d, BASE + 32'h0000_0048);
    chk("event raised", {31'h0, queue_paused_event_o}, 32'h1);
    ext_pause_i <= 7'h01;
    axr(OFS_STATUS);
    chk("raw sources", d & 32'hFFFF_0007, 32'h8100_0006);
    // Stop the queue first so that a dropped index pause cannot run unloaded entries
    axw(OFS_CFG, RST_WORD);
    axw(OFS_ENDIDX, 32'h0000_0001);
    axr(OFS_STATUS);
    chk("index apart", d & 32'hFFFF_0007, 32'h0100_0000);
    chk("event cleared", {31'h0, queue_paused_event_o}, 32'h0);
    axw(OFS_CURIDX, 32'h0000_0001);
    axr(OFS_STATUS);
    chk("index match", d & 32'hFFFF_0007, 32'h8100_0000);
  endtask : t_queue

  initial begin
    req = '0;
    rst_n_i = 1'b0;
    slow = 1'b1;
    ext_pause_i = '0;
    n_mismatch = 0;
    samples_checked = 0;
    ld(0, 32'h0000_0100, 32'hA5A5_0001);
    ld(1, {20'h0_0000, OFS_CMD}, 32'h0000_0C3D);
    ld(2, 32'h0000_0104, 32'hA5A5_000B);
    ld(3, {20'h0_0000, OFS_SETCLR}, 32'h0000_0001);
    ld(4, 32'h0000_0108, 32'hA5A5_000D);
    ld(5, {20'h0_0000, OFS_PTR}, BASE + 32'h0000_0040);
    ld(6, 32'h0000_010C, 32'hA5A5_000E);
    ld(8, {20'h0_0000, OFS_PAUSEEN}, 32'h0000_8000);
    ld(9, 32'h0000_0110, 32'hA5A5_000F);
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_queue();
    close_out();
  end
endmodule : tb_register_write_queue
